// ### hw/tcc_pkg.sv
// Purpose: Shared constants and types for the timer channel counter control block.
// Assumes: Avalon-MM slave with 32-bit data, byte addresses, one word per register.
// Notes:   Reserved control/status bits always read back as zero.
`default_nettype none
package tcc_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 5;
	localparam int CNT_W  = 24;
	localparam int PS_W   = 21;

	localparam logic [4:0] OFS_CSR   = 5'h00;
	localparam logic [4:0] OFS_LOAD  = 5'h04;
	localparam logic [4:0] OFS_MATCH = 5'h08;
	localparam logic [4:0] OFS_COUNT = 5'h0C;
	localparam logic [4:0] OFS_PRESC = 5'h10;

	localparam int BIT_RUN     = 0;
	localparam int BIT_WRAP_IE = 1;
	localparam int BIT_MATCH_IE = 2;
	localparam int MODE_LSB    = 4;
	localparam int BIT_INV     = 8;
	localparam int BIT_TRM     = 9;
	localparam int BIT_DIR     = 11;
	localparam int BIT_DI      = 12;
	localparam int BIT_DO      = 13;
	localparam int BIT_PCE     = 15;
	localparam int BIT_WRAP_F  = 20;
	localparam int BIT_MATCH_F = 21;
	localparam int PSRC_LSB    = 21;

	localparam logic [23:0] RSV_MASK   = 24'hCF4408;
	localparam logic [23:0] LOAD_RST   = 24'h000000;
	localparam logic [23:0] MATCH_RST  = 24'h000000;
	localparam logic [23:0] PRESC_RST  = 24'h000000;

	typedef enum logic [3:0] {
		MODE_GPIO     = 4'h0,
		MODE_PULSE    = 4'h1,
		MODE_TOGGLE   = 4'h2,
		MODE_EVENT    = 4'h3,
		MODE_WIDTH    = 4'h4,
		MODE_PERIOD   = 4'h5,
		MODE_CAPTURE  = 4'h6,
		MODE_PWM      = 4'h7,
		MODE_WD_PULSE = 4'h9,
		MODE_WD_TOG   = 4'hA
	} tcc_mode_t;

	typedef struct packed {
		logic       run;
		logic       wrap_ie;
		logic       match_ie;
		logic [3:0] mode;
		logic       pin_polarity_flip;
		logic       reload_on_match;
		logic       dir;
		logic       dout;
		logic       prescaled_clock_sel;
	} tcc_ctrl_t;

	localparam tcc_ctrl_t CTRL_RST = '0;
endpackage : tcc_pkg
`default_nettype wire

// ### hw/tcc_timer.sv
// Purpose: One 24-bit timer channel with preload/reload, pin I/O and status flags.
// Assumes: All inputs synchronous to CORE_CLK; one register access per request.
// Notes:   Acknowledge inputs stand for servicing of the matching interrupt.
// Summary of operation
// - Timer and watchdog modes preload count from load value on first tick after run.
// - With reload set, timer/watchdog reload on next tick after reaching match.
// - Modulation mode with reload set reloads on the tick after each overflow.
// - Width/period modes with reload and run preload on each active pin edge.
// - Without reload the count simply increments on each tick.
// - Watchdog modes also reload when load value is written while running.
// - Resets clear reload, direction, sample and drive bits.
// - Direction bit makes pin an output, only in general-purpose mode.
// - Sample bit holds pin level, inverted when polarity bit set.
// - General-purpose output drives drive bit onto pin, polarity applied.
// - Clock select picks half-rate or pin tick, or prescaler output.
// - Two-bit source field chooses what feeds the prescaler.
// - Overflow sets wrap flag; write one or service clears it.
// - Resets, stop, or clearing run also clear the wrap flag.
// - Match flag sets after N-M+1 ticks, or when a measurement completes.
// - Match flag clears by write one, service, resets, stop, or run clear.
// - Reserved control bits read zero; software writes zero there.
// - Write-only 24-bit load register feeds every preload and reload.
// - Match register compared every tick while running; unused in measurement.
// - Count register live in timing modes, captured on edge in measurement.
// - Polarity bit inverts sensed edge or level and driven output.
// - Four-bit mode field selects one of ten operating modes.
`default_nettype none
module tcc_timer #(
	parameter int PRESC_W = tcc_pkg::PS_W
) (
	input  wire logic                       CORE_CLK,
	input  wire logic                       RST,
	input  wire logic [tcc_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic                       AVS_READ,
	input  wire logic                       AVS_WRITE,
	input  wire logic [tcc_pkg::DATA_W-1:0] AVS_WRITEDATA,
	output logic      [tcc_pkg::DATA_W-1:0] AVS_READDATA,
	output logic                            AVS_WAITREQUEST,
	input  wire logic                       SW_RESET,
	input  wire logic                       STOP_IN,
	input  wire logic                       WRAP_ACK,
	input  wire logic                       MATCH_ACK,
	input  wire logic [2:0]                 PRESC_PIN_IN,
	input  wire logic                       TIMER_PIN_I,
	output logic                            TIMER_PIN_O,
	output logic                            TIMER_PIN_OE,
	output logic                            WRAP_IRQ,
	output logic                            MATCH_IRQ
);
	localparam int W = tcc_pkg::CNT_W;

	initial begin
		if (PRESC_W < 1 || PRESC_W > tcc_pkg::PS_W)
			$error("PRESC_W out of range");
	end

	tcc_pkg::tcc_ctrl_t ctrl;
	logic [W-1:0]       preload;
	logic [W-1:0]       match_val;
	logic [W-1:0]       cnt;
	logic [W-1:0]       capture;
	logic [PRESC_W-1:0] presc_div;
	logic [1:0]         presc_src;
	logic [PRESC_W-1:0] presc_cnt;
	logic               ack;
	logic               wrap_flag;
	logic               match_flag;
	logic               di;
	logic               di_prev;
	logic               half_tick;
	logic [2:0]         ppin_prev;
	logic               first_pend;
	logic               reload_pend;
	logic               out_lvl;

	logic               req;
	logic               wr_go;
	logic               wr_csr;
	logic               run_rise;
	logic               run_fall;
	logic               is_meas;
	logic               is_wd;
	logic               is_out;
	logic               rise;
	logic               fall;
	logic               src_tick;
	logic               presc_tick;
	logic               tick;
	logic               load_now;
	logic [W-1:0]       cnt_upd;
	logic               wrap;
	logic               match_hit;
	logic               meas_done;
	logic               meas_load;
	logic               wd_write;
	logic [W-1:0]       csr_rd;
	logic [3:0]         mode;

	// Bus handshake: one wait state, so read data always comes from a flop
	assign req             = AVS_READ || AVS_WRITE;
	assign AVS_WAITREQUEST = req && !ack;
	assign wr_go           = AVS_WRITE && ack;
	assign wr_csr          = wr_go && AVS_ADDRESS == tcc_pkg::OFS_CSR;
	assign run_rise        = wr_csr && AVS_WRITEDATA[tcc_pkg::BIT_RUN] && !ctrl.run;
	assign run_fall        = wr_csr && !AVS_WRITEDATA[tcc_pkg::BIT_RUN] && ctrl.run;

	assign mode    = ctrl.mode;
	assign is_meas = mode == tcc_pkg::MODE_WIDTH || mode == tcc_pkg::MODE_PERIOD
		|| mode == tcc_pkg::MODE_CAPTURE;
	assign is_wd   = mode == tcc_pkg::MODE_WD_PULSE || mode == tcc_pkg::MODE_WD_TOG;
	assign is_out  = mode == tcc_pkg::MODE_PULSE || mode == tcc_pkg::MODE_TOGGLE
		|| mode == tcc_pkg::MODE_PWM || is_wd;

	assign rise = di && !di_prev;
	assign fall = !di && di_prev;

	assign src_tick = presc_src == 2'h0 ? half_tick
		: PRESC_PIN_IN[presc_src - 2'h1] && !ppin_prev[presc_src - 2'h1];
	assign presc_tick = src_tick && presc_cnt == '0;

	assign tick = ctrl.run && (ctrl.prescaled_clock_sel ? presc_tick
		: (mode == tcc_pkg::MODE_EVENT ? rise : half_tick));

	assign load_now  = first_pend || reload_pend;
	assign cnt_upd   = load_now ? preload : cnt + 1'b1;
	assign wrap      = tick && !load_now && &cnt && !meas_load;
	assign match_hit = tick && !is_meas && cnt_upd == match_val;
	assign meas_done = ctrl.run && ((mode == tcc_pkg::MODE_WIDTH) ? fall
		: (is_meas && rise));
	assign meas_load = ctrl.run && ctrl.reload_on_match && rise
		&& (mode == tcc_pkg::MODE_WIDTH || mode == tcc_pkg::MODE_PERIOD);
	assign wd_write  = wr_go && AVS_ADDRESS == tcc_pkg::OFS_LOAD && ctrl.run && is_wd;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ack <= 1'b0;
		end else begin
			ack <= req && !ack;
		end
	end

	// Control register; software reset drops every control field
	always_ff @(posedge CORE_CLK) begin
		if (RST || SW_RESET) begin
			ctrl <= tcc_pkg::CTRL_RST;
		end else if (wr_csr) begin
			ctrl.run      <= AVS_WRITEDATA[tcc_pkg::BIT_RUN];
			ctrl.wrap_ie  <= AVS_WRITEDATA[tcc_pkg::BIT_WRAP_IE];
			ctrl.match_ie <= AVS_WRITEDATA[tcc_pkg::BIT_MATCH_IE];
			ctrl.mode     <= AVS_WRITEDATA[tcc_pkg::MODE_LSB +: 4];
			ctrl.pin_polarity_flip      <= AVS_WRITEDATA[tcc_pkg::BIT_INV];
			ctrl.reload_on_match      <= AVS_WRITEDATA[tcc_pkg::BIT_TRM];
			ctrl.dir      <= AVS_WRITEDATA[tcc_pkg::BIT_DIR];
			ctrl.dout     <= AVS_WRITEDATA[tcc_pkg::BIT_DO];
			ctrl.prescaled_clock_sel      <= AVS_WRITEDATA[tcc_pkg::BIT_PCE];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			preload   <= tcc_pkg::LOAD_RST;
			match_val <= tcc_pkg::MATCH_RST;
			presc_div <= tcc_pkg::PRESC_RST[PRESC_W-1:0];
			presc_src <= tcc_pkg::PRESC_RST[tcc_pkg::PSRC_LSB +: 2];
		end else if (wr_go) begin
			if (AVS_ADDRESS == tcc_pkg::OFS_LOAD)
				preload <= AVS_WRITEDATA[W-1:0];
			if (AVS_ADDRESS == tcc_pkg::OFS_MATCH)
				match_val <= AVS_WRITEDATA[W-1:0];
			if (AVS_ADDRESS == tcc_pkg::OFS_PRESC) begin
				presc_div <= AVS_WRITEDATA[PRESC_W-1:0];
				presc_src <= AVS_WRITEDATA[tcc_pkg::PSRC_LSB +: 2];
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST || SW_RESET) begin
			di        <= 1'b0;
			di_prev   <= 1'b0;
			ppin_prev <= 3'h0;
		end else begin
			di        <= TIMER_PIN_I ^ ctrl.pin_polarity_flip;
			di_prev   <= di;
			ppin_prev <= PRESC_PIN_IN;
		end
	end

	// Half-rate enable and prescaler divider
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			half_tick <= 1'b0;
			presc_cnt <= '0;
		end else begin
			half_tick <= !half_tick;
			if (src_tick)
				presc_cnt <= presc_tick ? presc_div : presc_cnt - 1'b1;
		end
	end

	// Counter and its preload/reload sequencing
	always_ff @(posedge CORE_CLK) begin
		if (RST || SW_RESET || run_rise) begin
			cnt         <= '0;
			first_pend  <= run_rise;
			reload_pend <= 1'b0;
		end else if (wd_write) begin
			cnt         <= AVS_WRITEDATA[W-1:0];
			first_pend  <= 1'b0;
			reload_pend <= 1'b0;
		end else if (meas_load) begin
			cnt        <= preload;
			first_pend <= 1'b0;
		end else if (tick) begin
			cnt        <= cnt_upd;
			first_pend <= 1'b0;
			reload_pend <= ctrl.reload_on_match && ((match_hit && mode != tcc_pkg::MODE_PWM)
				|| (wrap && mode == tcc_pkg::MODE_PWM));
		end else if (!ctrl.reload_on_match) begin
			reload_pend <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			capture <= '0;
		end else if (meas_done) begin
			capture <= cnt;
		end
	end

	// wrap flag; set beats write-one and service
	always_ff @(posedge CORE_CLK) begin
		if (RST || SW_RESET || STOP_IN || run_fall) begin
			wrap_flag <= 1'b0;
		end else if (wrap) begin
			wrap_flag <= 1'b1;
		end else if (WRAP_ACK || (wr_csr && AVS_WRITEDATA[tcc_pkg::BIT_WRAP_F])) begin
			wrap_flag <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST || SW_RESET || STOP_IN || run_fall) begin
			match_flag <= 1'b0;
		end else if (match_hit || meas_done) begin
			match_flag <= 1'b1;
		end else if (MATCH_ACK || (wr_csr && AVS_WRITEDATA[tcc_pkg::BIT_MATCH_F])) begin
			match_flag <= 1'b0;
		end
	end

	// Output waveform level before polarity
	always_ff @(posedge CORE_CLK) begin
		if (RST || SW_RESET || run_rise) begin
			out_lvl <= 1'b0;
		end else if (tick) begin
			case (mode)
				tcc_pkg::MODE_PULSE:    out_lvl <= match_hit;
				tcc_pkg::MODE_TOGGLE:   out_lvl <= out_lvl ^ match_hit;
				tcc_pkg::MODE_PWM:      out_lvl <= wrap | (out_lvl & !match_hit);
				tcc_pkg::MODE_WD_PULSE: out_lvl <= wrap;
				tcc_pkg::MODE_WD_TOG:   out_lvl <= out_lvl ^ wrap;
				default:                out_lvl <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			TIMER_PIN_O  <= 1'b0;
			TIMER_PIN_OE <= 1'b0;
		end else if (mode == tcc_pkg::MODE_GPIO) begin
			TIMER_PIN_O  <= ctrl.dout ^ ctrl.pin_polarity_flip;
			TIMER_PIN_OE <= ctrl.dir;
		end else begin
			TIMER_PIN_O  <= out_lvl ^ ctrl.pin_polarity_flip;
			TIMER_PIN_OE <= is_out;
		end
	end

	always_comb begin
		csr_rd = '0;
		csr_rd[tcc_pkg::BIT_RUN]      = ctrl.run;
		csr_rd[tcc_pkg::BIT_WRAP_IE]  = ctrl.wrap_ie;
		csr_rd[tcc_pkg::BIT_MATCH_IE] = ctrl.match_ie;
		csr_rd[tcc_pkg::MODE_LSB +: 4] = ctrl.mode;
		csr_rd[tcc_pkg::BIT_INV]      = ctrl.pin_polarity_flip;
		csr_rd[tcc_pkg::BIT_TRM]      = ctrl.reload_on_match;
		csr_rd[tcc_pkg::BIT_DIR]      = ctrl.dir;
		csr_rd[tcc_pkg::BIT_DI]       = di;
		csr_rd[tcc_pkg::BIT_DO]       = ctrl.dout;
		csr_rd[tcc_pkg::BIT_PCE]      = ctrl.prescaled_clock_sel;
		csr_rd[tcc_pkg::BIT_WRAP_F]   = wrap_flag;
		csr_rd[tcc_pkg::BIT_MATCH_F]  = match_flag;
	end

	// Load register is write-only, so its offset reads zero like unmapped ones
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			AVS_READDATA <= '0;
		end else if (AVS_READ && !ack) begin
			case (AVS_ADDRESS)
				tcc_pkg::OFS_CSR:   AVS_READDATA <= {8'h00, csr_rd};
				tcc_pkg::OFS_MATCH: AVS_READDATA <= {8'h00, match_val};
				tcc_pkg::OFS_COUNT: AVS_READDATA <= {8'h00, is_meas ? capture : cnt};
				tcc_pkg::OFS_PRESC: AVS_READDATA <= 32'(presc_div)
					| ({30'h0, presc_src} << tcc_pkg::PSRC_LSB);
				default:            AVS_READDATA <= '0;
			endcase
		end
	end

	assign WRAP_IRQ  = wrap_flag && ctrl.wrap_ie;
	assign MATCH_IRQ = match_flag && ctrl.match_ie;

	sequence s_first_tick;
		first_pend && tick && !is_meas && !wd_write;
	endsequence

	sequence s_reload_tick;
		reload_pend && !first_pend && tick && !is_meas && !wd_write;
	endsequence

	AST_PRELOAD: assert property (@(posedge CORE_CLK) disable iff (RST)
		s_first_tick |=> cnt == $past(preload)) else $error("no preload on first tick");

	AST_RELOAD: assert property (@(posedge CORE_CLK) disable iff (RST)
		s_reload_tick |=> cnt == $past(preload)) else $error("no reload after event");

	AST_FREE_RUN: assert property (@(posedge CORE_CLK) disable iff (RST)
		(!ctrl.reload_on_match && !first_pend && tick && !SW_RESET && !wr_go)
		|=> cnt == $past(cnt) + 1'b1) else $error("free-run count not incremented");

	AST_WRAP_SET: assert property (@(posedge CORE_CLK) disable iff (RST)
		(wrap && !SW_RESET && !STOP_IN && !run_fall && !wd_write) |=> wrap_flag && cnt == '0)
		else $error("overflow did not set wrap flag");

	AST_FLAGS_IDLE: assert property (@(posedge CORE_CLK) disable iff (RST)
		!ctrl.run |-> !wrap_flag && !match_flag) else $error("flag set while stopped");

	AST_MATCH_SET: assert property (@(posedge CORE_CLK) disable iff (RST)
		(match_hit && !SW_RESET && !STOP_IN && !run_fall) |=> match_flag)
		else $error("match did not set flag");

	AST_SW_RESET: assert property (@(posedge CORE_CLK) disable iff (RST)
		SW_RESET |=> !ctrl.reload_on_match && !ctrl.dir && !ctrl.dout && !di && !ctrl.pin_polarity_flip)
		else $error("software reset left control bits set");

	AST_GPIO_DRIVE: assert property (@(posedge CORE_CLK) disable iff (RST)
		(mode == tcc_pkg::MODE_GPIO) |=> TIMER_PIN_OE == $past(ctrl.dir)
		&& TIMER_PIN_O == $past(ctrl.dout ^ ctrl.pin_polarity_flip)) else $error("pin drive wrong");

	AST_SAMPLE: assert property (@(posedge CORE_CLK) disable iff (RST)
		!SW_RESET ##1 1'b1 |-> di == $past(TIMER_PIN_I ^ ctrl.pin_polarity_flip))
		else $error("sample bit wrong");

	AST_RSV_ZERO: assert property (@(posedge CORE_CLK) disable iff (RST)
		(AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == tcc_pkg::OFS_CSR)
		|-> (AVS_READDATA[23:0] & tcc_pkg::RSV_MASK) == '0) else $error("reserved bit set");

	AST_BUS_ANSWER: assert property (@(posedge CORE_CLK) disable iff (RST)
		(req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST) else $error("bus answer late");
endmodule : tcc_timer
`default_nettype wire

// ### test/tcc_pin_model.sv
// Purpose: Far side of the timer pin: a signal source when the channel listens, a load otherwise.
// Assumes: The bench picks the level the source presents and whether it drives at all.
// Notes:   An undriven pin has no pull, so it flips every cycle and a stale level never passes.
`default_nettype none
module tcc_pin_model (
	input  wire logic clk,
	input  wire logic src_en,
	input  wire logic src_lvl,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output logic      pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic float_lvl = 1'b0;

	always_ff @(posedge clk) begin
		float_lvl <= ~float_lvl;
	end

	always_comb begin
		if (pin_oe)
			pin_i = pin_o;
		else if (src_en)
			pin_i = src_lvl;
		else
			pin_i = float_lvl;
	end
endmodule : tcc_pin_model
`default_nettype wire

// ### test/tb.sv
// Purpose: Self-checking bench for the timer channel, compared with a counting model.
// Assumes: One wait state per bus access; pin and prescaler edges made by the bench.
// Notes:   Event-count and prescaled modes keep the tick count exact.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  adr = 5'h00;
	logic        rd_en = 1'b0;
	logic        wr_en = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        wreq;
	logic        sw_rst = 1'b0;
	logic        stop = 1'b0;
	logic        wack = 1'b0;
	logic        mack = 1'b0;
	logic [2:0]  ppin = 3'h0;
	logic        src_lvl = 1'b0;
	logic        pin_i;
	logic        pin_o;
	logic        pin_oe;
	logic        wirq;
	logic        mirq;
	logic [31:0] q;
	logic        m_go;
	logic        m_hit;
	logic        m_wf;
	logic        m_mf;
	int          m_cnt;
	int          m_ld;
	int          m_cmp;
	int          m_trm;
	int          n_fail = 0;
	int          total_checks = 0;
	int          seed = 8640;
	int          d;
	int          cfg;

	tcc_timer DUT (.CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
		.AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
		.SW_RESET(sw_rst), .STOP_IN(stop), .WRAP_ACK(wack), .MATCH_ACK(mack),
		.PRESC_PIN_IN(ppin), .TIMER_PIN_I(pin_i), .TIMER_PIN_O(pin_o),
		.TIMER_PIN_OE(pin_oe), .WRAP_IRQ(wirq), .MATCH_IRQ(mirq));

	tcc_pin_model PIN (.clk(clk), .src_en(1'b1), .src_lvl(src_lvl), .pin_o(pin_o),
		.pin_oe(pin_oe), .pin_i(pin_i));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Hold the request until waitrequest is sampled low, then release
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wdat <= dat;
		wr_en <= w;
		rd_en <= ~w;
		@(posedge clk);
		while (wreq !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n == 20)
			chk("waitrequest", 32'h1, 32'h0);
		q = rdat;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask : bus

	task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask : rdchk

	task automatic model_tick();
		if (!m_go || (m_trm != 0 && m_hit))
			m_cnt = m_ld;
		else begin
			m_cnt = (m_cnt + 1) & 32'hFFFFFF;
			if (m_cnt == 0)
				m_wf = 1'b1;
		end
		m_go = 1'b1;
		m_hit = (m_cnt == m_cmp);
		if (m_hit)
			m_mf = 1'b1;
	endtask : model_tick

	task automatic edge_pulse(input int which);
		@(posedge clk);
		if (which == 0) src_lvl <= 1'b1;
		else ppin[0] <= 1'b1;
		repeat (3) @(posedge clk);
		src_lvl <= 1'b0;
		ppin[0] <= 1'b0;
		repeat (4) @(posedge clk);
		model_tick();
	endtask : edge_pulse

	task automatic flags_chk();
		bus(1'b0, tcc_pkg::OFS_CSR, 32'h0);
		chk("flags", 32'((q >> 20) & 3), 32'({m_mf, m_wf}));
		chk("wrap_irq", 32'(wirq), 32'(m_wf));
		chk("match_irq", 32'(mirq), 32'(m_mf));
	endtask : flags_chk

	initial begin
		#500000;
		n_fail++;
		end_sim();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdchk("csr_rst", tcc_pkg::OFS_CSR, 32'h0);
		rdchk("count_rst", tcc_pkg::OFS_COUNT, 32'h0);
		bus(1'b1, tcc_pkg::OFS_MATCH, 32'h00123456);
		rdchk("match_rw", tcc_pkg::OFS_MATCH, 32'h00123456);
		bus(1'b1, tcc_pkg::OFS_LOAD, 32'h00ABCDEF);
		rdchk("load_wo", tcc_pkg::OFS_LOAD, 32'h0);
		bus(1'b1, 5'h14, 32'hFFFFFFFF);
		rdchk("unmapped", 5'h14, 32'h0);
		// Reserved and flag bits written as ones on purpose, run left clear
		bus(1'b1, tcc_pkg::OFS_CSR, 32'h00FFFFFE);
		rdchk("csr_all", tcc_pkg::OFS_CSR, 32'h0000BBF6);
		@(posedge clk) sw_rst <= 1'b1;
		@(posedge clk) sw_rst <= 1'b0;
		rdchk("csr_swrst", tcc_pkg::OFS_CSR, 32'h0);
		for (int v = 0; v < 4; v++) begin
			src_lvl <= v[1];
			bus(1'b1, tcc_pkg::OFS_CSR, 32'(v[0]) << 8);
			// Pin enable drops one edge late and the sample takes one more edge
			repeat (2) @(posedge clk);
			rdchk("pin_sample", tcc_pkg::OFS_CSR, {v[1] ^ v[0], 3'h0, v[0], 8'h00});
			bus(1'b1, tcc_pkg::OFS_CSR, (32'(v[0]) << 8) | (32'(v[1]) << 13) | 32'h800);
			repeat (2) @(posedge clk);
			chk("pin_oe", 32'(pin_oe), 32'h1);
			chk("pin_out", 32'(pin_o), 32'(v[1] ^ v[0]));
		end
		src_lvl <= 1'b0;
		bus(1'b1, tcc_pkg::OFS_CSR, 32'h2830);
		repeat (2) @(posedge clk);
		chk("pin_oe_m3", 32'(pin_oe), 32'h0);
		for (int i = 0; i < 3; i++) begin
			m_ld = (i == 0) ? 32'hFFFFFE : ($random(seed) & 32'hFFFFFF);
			d = (i == 0) ? 3 : ($random(seed) & 3);
			m_cmp = (m_ld + d) & 32'hFFFFFF;
			m_trm = (i != 1) ? 1 : 0;
			{m_go, m_hit, m_wf, m_mf} = 4'h0;
			cfg = 32'h37 | (m_trm << 9);
			bus(1'b1, tcc_pkg::OFS_CSR, 32'h0);
			bus(1'b1, tcc_pkg::OFS_LOAD, 32'(m_ld));
			bus(1'b1, tcc_pkg::OFS_MATCH, 32'(m_cmp));
			bus(1'b1, tcc_pkg::OFS_CSR, 32'(cfg));
			for (int k = 0; k < d + 3; k++) begin
				edge_pulse(0);
				rdchk("count", tcc_pkg::OFS_COUNT, 32'(m_cnt));
				flags_chk();
			end
			if (i == 0) begin
				// Clear one flag with a single write, zero to the other
				bus(1'b1, tcc_pkg::OFS_CSR, 32'(cfg) | 32'h100000);
				m_wf = 1'b0;
				flags_chk();
				@(posedge clk) mack <= 1'b1;
				@(posedge clk) mack <= 1'b0;
				m_mf = 1'b0;
			end else if (i == 1) begin
				@(posedge clk) wack <= 1'b1;
				@(posedge clk) wack <= 1'b0;
				m_wf = 1'b0;
				flags_chk();
				@(posedge clk) stop <= 1'b1;
				@(posedge clk) stop <= 1'b0;
				{m_wf, m_mf} = 2'b00;
			end else begin
				bus(1'b1, tcc_pkg::OFS_CSR, 32'h0);
				{m_wf, m_mf} = 2'b00;
			end
			flags_chk();
		end
		// Clock select changed only while stopped
		bus(1'b1, tcc_pkg::OFS_CSR, 32'h0);
		bus(1'b1, tcc_pkg::OFS_PRESC, 32'h00200000);
		{m_go, m_hit, m_wf, m_mf} = 4'h0;
		m_ld = 32'h10;
		m_cmp = 32'hFFFFFF;
		m_trm = 0;
		bus(1'b1, tcc_pkg::OFS_LOAD, 32'(m_ld));
		bus(1'b1, tcc_pkg::OFS_MATCH, 32'(m_cmp));
		bus(1'b1, tcc_pkg::OFS_CSR, 32'h8091);
		edge_pulse(1);
		edge_pulse(1);
		rdchk("count_presc", tcc_pkg::OFS_COUNT, 32'(m_cnt));
		bus(1'b1, tcc_pkg::OFS_LOAD, 32'h200);
		rdchk("count_wdload", tcc_pkg::OFS_COUNT, 32'h200);
		// Period measurement clocked by prescaler pulses, load value now 0x200
		bus(1'b1, tcc_pkg::OFS_CSR, 32'h0);
		bus(1'b1, tcc_pkg::OFS_CSR, 32'h8251);
		edge_pulse(0);
		edge_pulse(1);
		edge_pulse(1);
		edge_pulse(0);
		rdchk("count_meas", tcc_pkg::OFS_COUNT, 32'h202);
		bus(1'b0, tcc_pkg::OFS_CSR, 32'h0);
		chk("meas_flag", 32'((q >> 21) & 1), 32'h1);
		end_sim();
	end
endmodule : tb
`default_nettype wire
